// file: test_external_chip_select_bus.sv
// testbench for the external chip-select bus front end
`include "xcsb_map.svh"
module test_external_chip_select_bus
   import xcsb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk = 1'b0, rstn = 1'b0, reqValid = 1'b0, shareAckMode = 1'b1, ackEn = 1'b1;
   logic [1:0] straps = 2'h0;
   logic [2:0] cfgWrite = 3'h0;
   logic [7:0] ackDelay = 8'h02;
   xcsb_cfg_t cfgIn [`XCSB_NUM_CS];
   xcsb_req_t req = '0;
   xcsb_rsp_t rsp, lastRsp;
   logic reqReady, rspValid, globalMode, extWriteN, readStrobeN, transfer_ack_n;
   logic [21:0] extAddr;
   logic [15:0] extDataOut, extDataIn;
   logic [2:0] chipSelN, csAnd = 3'h7;
   logic [1:0] lane_strobe_n;
   int nFail = 0, checksDone = 0, nRsp = 0, cyc = 0, lat = 0;
   xcsb_external_bus_unit xcsb_external_bus_unit_i (
      .clk(clk), .rstn(rstn), .boot_ack_pin(straps[1]), .boot_width_pin(straps[0]), .cfgIn(cfgIn),
      .cfgWrite(cfgWrite), .reqValid(reqValid), .reqReady(reqReady), .req(req), .rspValid(rspValid),
      .rsp(rsp), .globalMode(globalMode), .bus_clock_out(), .extAddr(extAddr), .extWriteN(extWriteN),
      .extDataOut(extDataOut), .extDataOe(), .extDataIn(extDataIn), .chipSelN(chipSelN),
      .readStrobeN(readStrobeN), .lane_strobe_n(lane_strobe_n), .shareAckMode(shareAckMode),
      .addr_strobe_n(), .addrStrobeOe(), .transfer_ack_n(transfer_ack_n)
   );
   xcsb_mem_model xcsb_mem_model_i (
      .clk(clk), .extAddr(extAddr), .extWriteN(extWriteN), .extDataOut(extDataOut), .chipSelN(chipSelN),
      .readStrobeN(readStrobeN), .lane_strobe_n(lane_strobe_n), .ackEn(ackEn), .ackDelay(ackDelay),
      .extDataIn(extDataIn), .transfer_ack_n(transfer_ack_n)
   );
   // ==========================================================
   // clock, monitors and closing
   always #2 clk = ~clk;
   // selects seen per access; a hang is cut short here
   always @(posedge clk) begin
      csAnd = csAnd & chipSelN;
      cyc++;
      if (cyc == 20000) begin
         nFail++;
         testDone();
      end
   end
   // answers stand one cycle, so look at them mid-cycle
   always @(negedge clk) begin
      if (rspValid === 1'b1) begin
         nRsp++;
         lastRsp = rsp;
      end
   end
   task automatic check(input logic [35:0] seen, input logic [35:0] exp);
      checksDone++;
      if (seen !== exp) begin
         nFail++;
         $display("[FAIL] %0t ns: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   task automatic testDone();
      $display("checks %0d, mismatches %0d", checksDone, nFail);
      if (nFail == 0 && checksDone > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask
   // ==========================================================
   // access tasks
   task automatic doReset(input logic [1:0] p);
      rstn <= 1'b0;
      straps <= p;
      shareAckMode <= !p[1];
      ackEn <= !p[1];
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      repeat (6) @(posedge clk);
      check(36'(globalMode), 36'h1);
   endtask
   // hold the request until taken, then wait for its answer
   task automatic access(input logic [31:0] ad, input logic wr, input logic [1:0] sz, input logic [31:0] wd);
      logic rdy;
      int n0;
      n0 = nRsp;
      csAnd = 3'h7;
      lat = 0;
      reqValid <= 1'b1;
      req <= '{ad, wr, sz, wd};
      do begin
         @(negedge clk) rdy = reqReady;
         @(posedge clk);
      end while (!rdy);
      reqValid <= 1'b0;
      while (nRsp == n0 && lat < 600) begin
         @(posedge clk);
         lat++;
      end
      check(36'(nRsp - n0), 36'h1);
   endtask
   task automatic setCfg(input int i, input xcsb_cfg_t c);
      cfgIn[i] <= c;
      cfgWrite <= 3'h1 << i;
      @(posedge clk);
      cfgWrite <= 3'h0;
      repeat (4) @(posedge clk);
   endtask
   function automatic xcsb_cfg_t mk(input logic [15:0] b, m, input logic wp, input logic [3:0] ws,
      input logic aa, input logic [1:0] pw);
      return '{b, m, wp, 1'b1, ws, aa, pw, 1'b0};
   endfunction
   // ==========================================================
   // scenarios
   initial begin
      xcsb_cfg_t c;
      logic rdy;
      int n0, k;
      for (int i = 0; i < 3; i++) cfgIn[i] = '0;
      // every strap pattern boots select zero on any address
      for (int p = 0; p < 4; p++) begin
         doReset(2'(p));
         access(32'h1234_0004, 1'b0, `XCSB_SZ_WORD, 32'h0);
         check({lastRsp.rdata, lastRsp.err, csAnd}, {32'hA4A5_A6A7, 4'h6});
      end
      // wide boot port: word write back, odd byte, misaligned halfword
      access(32'h0000_0008, 1'b1, `XCSB_SZ_WORD, 32'h1122_3344);
      access(32'h0000_0008, 1'b0, `XCSB_SZ_WORD, 32'h0);
      check({lastRsp.rdata, lastRsp.err, csAnd}, {32'h1122_3344, 4'h6});
      access(32'h0000_0009, 1'b0, `XCSB_SZ_BYTE, 32'h0);
      check(36'({lastRsp.rdata[7:0], lastRsp.err}), 36'h044);
      access(32'h0000_000A, 1'b1, `XCSB_SZ_BYTE, 32'h0000_005A);
      access(32'h0000_000A, 1'b0, `XCSB_SZ_BYTE, 32'h0);
      check(36'({lastRsp.rdata[7:0], lastRsp.err}), 36'h0B4);
      access(32'h0000_0008, 1'b0, `XCSB_SZ_WORD, 32'h0);
      check({lastRsp.rdata, lastRsp.err, csAnd}, {32'h1122_5A44, 4'h6});
      access(32'h0000_0009, 1'b0, `XCSB_SZ_HALF, 32'h0);
      check(36'({lastRsp.err, csAnd}), 36'hF);
      // select one stays dead until select zero is valid
      shareAckMode <= 1'b1;
      ackEn <= 1'b1;
      setCfg(1, mk(16'h0030, 16'h0000, 1'b0, 4'h2, 1'b1, 2'h1));
      access(32'h0030_0006, 1'b0, `XCSB_SZ_HALF, 32'h0);
      check(36'(csAnd), 36'h6);
      setCfg(0, mk(16'h0000, 16'h000F, 1'b0, 4'h2, 1'b1, 2'h2));
      check(36'(globalMode), 36'h0);
      access(32'h0008_0004, 1'b0, `XCSB_SZ_WORD, 32'h0);
      check({lastRsp.rdata, lastRsp.err, csAnd}, {32'hA4A5_A6A7, 4'h6});
      access(32'h0050_0000, 1'b0, `XCSB_SZ_WORD, 32'h0);
      check(36'({lastRsp.err, csAnd}), 36'hF);
      access(32'h0030_0006, 1'b0, `XCSB_SZ_HALF, 32'h0);
      check(36'({lastRsp.rdata[15:0], lastRsp.err, csAnd}), 36'hA6A75);
      // overlap: both selects, only the slow far side may end it
      ackDelay <= 8'h1E;
      setCfg(2, mk(16'h0030, 16'h0000, 1'b0, 4'h0, 1'b1, 2'h2));
      access(32'h0030_0004, 1'b0, `XCSB_SZ_WORD, 32'h0);
      check({lastRsp.rdata, lastRsp.err, csAnd}, {32'hA4A5_A6A7, 4'h1});
      check(36'(lat >= 30), 36'h1);
      ackDelay <= 8'h02;
      setCfg(2, mk(16'h0040, 16'h0000, 1'b1, 4'h2, 1'b1, 2'h2));
      access(32'h0040_0000, 1'b1, `XCSB_SZ_HALF, 32'h0000_5555);
      check(36'({lastRsp.err, csAnd}), 36'h7);
      c = mk(16'h0000, 16'h000F, 1'b0, 4'h2, 1'b1, 2'h2);
      c.valid = 1'b0;
      setCfg(0, c);
      check(36'(globalMode), 36'h0);
      // far side stalls: queue fills until refused, then drains whole
      setCfg(1, mk(16'h0030, 16'h0000, 1'b0, 4'h0, 1'b0, 2'h2));
      ackEn <= 1'b0;
      n0 = nRsp;
      k = 0;
      reqValid <= 1'b1;
      req <= '{32'h0030_0004, 1'b0, `XCSB_SZ_HALF, 32'h0};
      repeat (40) begin
         @(negedge clk) rdy = reqReady;
         @(posedge clk);
         if (rdy) k++;
      end
      reqValid <= 1'b0;
      check(36'(k >= 16 && k <= 17), 36'h1);
      ackEn <= 1'b1;
      for (int t = 0; t < 3000 && nRsp - n0 < k; t++) @(posedge clk);
      check(36'(nRsp - n0), 36'(k));
      testDone();
   end
endmodule

// file: xcsb_external_bus_unit.sv
// external bus unit: window decode, lane strobes and bus cycle engine
`include "xcsb_map.svh"
module xcsb_external_bus_unit
   import xcsb_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // boot straps
   input wire logic boot_ack_pin,
   input wire logic boot_width_pin,
   // window configuration, one entry per chip select
   input wire xcsb_cfg_t cfgIn [`XCSB_NUM_CS],
   input wire logic [`XCSB_NUM_CS-1:0] cfgWrite,
   // internal request side
   input wire logic reqValid,
   output logic reqReady,
   input wire xcsb_req_t req,
   // internal answer side
   output logic rspValid,
   output xcsb_rsp_t rsp,
   // status
   output logic globalMode,
   // external bus
   output logic bus_clock_out,
   output logic [`XCSB_ADDR_W-1:0] extAddr,
   output logic extWriteN,
   output logic [15:0] extDataOut,
   output logic extDataOe,
   input wire logic [15:0] extDataIn,
   output logic [`XCSB_NUM_CS-1:0] chipSelN,
   output logic readStrobeN,
   output logic [1:0] lane_strobe_n,
   // shared strobe and acknowledge pin
   input wire logic shareAckMode,
   output logic addr_strobe_n,
   output logic addrStrobeOe,
   input wire logic transfer_ack_n
);
   //==========================================================
   // input synchronisers
   logic ackMeta;
   logic ackSync;
   logic bwMeta;
   logic bwSync;
   logic baMeta;
   logic baSync;
   logic [15:0] dinMeta;
   logic [15:0] dinSync;
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         ackMeta <= 1'b1;
         ackSync <= 1'b1;
         dinMeta <= 16'h0000;
         dinSync <= 16'h0000;
      end else begin
         ackMeta <= transfer_ack_n;
         ackSync <= ackMeta;
         dinMeta <= extDataIn;
         dinSync <= dinMeta;
      end
   end
   // straps run through reset, so the first edge after release already sees the pins
   always_ff @(posedge clk) begin
      bwMeta <= boot_width_pin;
      bwSync <= bwMeta;
      baMeta <= boot_ack_pin;
      baSync <= baMeta;
   end

   //==========================================================
   // configuration registers
   xcsb_cfg_t cfg [`XCSB_NUM_CS];
   logic strapDone;
   logic everValid;
   // select zero takes its width and ack from the straps once after release
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < `XCSB_NUM_CS; i++) begin
            cfg[i] <= '0;
         end
         strapDone <= 1'b0;
      end else begin
         for (int i = 0; i < `XCSB_NUM_CS; i++) begin
            if (cfgWrite[i]) begin
               cfg[i] <= cfgIn[i];
            end
         end
         if (!strapDone && !cfgWrite[0]) begin
            cfg[0].autoAck <= baSync;
            cfg[0].portWidth <= bwSync ? 2'h2 : 2'h1;
            cfg[0].waitCount <= 4'hF;
            strapDone <= 1'b1;
         end
      end
   end
   // global mode ends when zero first goes valid; only reset restores it
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         everValid <= 1'b0;
      end else if (cfg[0].valid) begin
         everValid <= 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         globalMode <= 1'b1;
      end else begin
         globalMode <= !everValid && !cfg[0].valid;
      end
   end

   //==========================================================
   // window decode
   function automatic logic winHit(input xcsb_cfg_t c, input logic [31:0] a, input logic wr);
      logic [15:0] diff;
      diff = (a[31:`XCSB_HI_LSB] ^ c.base) & ~c.ignoreMask;
      return c.valid && (diff == 16'h0000) && !(wr && c.writeProtect);
   endfunction
   function automatic logic isWide(input logic [1:0] pw);
      return pw[1];
   endfunction

   xcsb_req_t head;
   logic headValid;
   logic headReady;
   logic [`XCSB_NUM_CS-1:0] hit;
   logic [`XCSB_NUM_CS-1:0] prot;
   logic gmode;
   assign gmode = !everValid && !cfg[0].valid;
   always_comb begin
      hit = '0;
      prot = '0;
      if (gmode) begin
         hit[0] = 1'b1;
      end else begin
         for (int i = 0; i < `XCSB_NUM_CS; i++) begin
            hit[i] = winHit(cfg[i], head.addr, head.write);
            prot[i] = head.write && cfg[i].writeProtect && winHit(cfg[i], head.addr, 1'b0);
         end
      end
   end

   xcsb_fifo #(.WIDTH($bits(xcsb_req_t)), .DEPTH(`XCSB_FIFO_DEPTH)) reqFifo (
      .clk(clk),
      .rstn(rstn),
      .inValid(reqValid),
      .inReady(reqReady),
      .inData(req),
      .outValid(headValid),
      .outReady(headReady),
      .outData(head)
   );

   //==========================================================
   // cycle engine
   xcsb_state_t state;
   logic [`XCSB_NUM_CS-1:0] curSel;
   logic curWide;
   logic curAuto;
   logic curBem;
   logic [1:0] curSize;
   logic [3:0] curWait;
   logic [3:0] waitCnt;
   logic [2:0] beatsLeft;
   logic [31:0] curAddr;
   logic [31:0] shiftData;
   logic [31:0] gather;
   logic cycleEnd;
   logic ackSeen;
   logic multiHit;
   logic noHit;
   logic misalign;
   logic headWide;
   logic [2:0] nBeats;
   logic popDone;
   logic [31:0] stepAddr;
   // next beat address: one byte on a narrow port, two on a wide one
   assign stepAddr = curAddr + (curWide ? 32'h2 : 32'h1);
   assign multiHit = (hit != 3'h0) && ((hit & (hit - 3'h1)) != 3'h0);
   assign noHit = (hit == 3'h0);
   assign headWide = multiHit ? 1'b1 : isWide(cfg[0].portWidth & {2{hit[0]}} |
      cfg[1].portWidth & {2{hit[1]}} | cfg[2].portWidth & {2{hit[2]}});
   assign misalign = headWide && (head.size != `XCSB_SZ_BYTE) && head.addr[0];
   // beats per request: byte 1, halfword 2 (1 wide), word and line 4 (2 wide)
   always_comb begin
      unique case (head.size)
         `XCSB_SZ_BYTE: nBeats = 3'h1;
         `XCSB_SZ_HALF: nBeats = headWide ? 3'h1 : 3'h2;
         default: nBeats = headWide ? `XCSB_BYTES_16 : `XCSB_BYTES_8;
      endcase
   end
   assign ackSeen = shareAckMode && !ackSync;
   // external acknowledge ends the cycle at once when shareAckMode is set; auto-ack only after its wait count
   assign cycleEnd = ackSeen || (curAuto && (waitCnt == curWait));
   // the request leaves the queue when its last beat is done, or at once on an error
   assign popDone = (state == ST_HOLD) && (beatsLeft == 3'h1);
   assign headReady = ((state == ST_IDLE) && headValid && (noHit || misalign)) || popDone;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= ST_IDLE;
         curSel <= '0;
         curWide <= 1'b0;
         curAuto <= 1'b0;
         curBem <= 1'b0;
         curSize <= `XCSB_SZ_BYTE;
         curWait <= 4'h0;
         waitCnt <= 4'h0;
         beatsLeft <= 3'h0;
         curAddr <= 32'h0000_0000;
         shiftData <= 32'h0000_0000;
         gather <= 32'h0000_0000;
         extWriteN <= 1'b1;
         rspValid <= 1'b0;
         rsp <= '0;
      end else begin
         rspValid <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (headValid && (noHit || misalign)) begin
                  rspValid <= 1'b1;
                  rsp.err <= misalign || (prot == '0);  // protected write ends quietly
                  rsp.rdata <= 32'h0000_0000;
               end else if (headValid) begin
                  curSel <= hit;
                  curWide <= headWide;
                  curAuto <= multiHit ? 1'b0 : (|(hit & {cfg[2].autoAck, cfg[1].autoAck, cfg[0].autoAck}));
                  curBem <= |(hit & {cfg[2].readLaneStrobeMode, cfg[1].readLaneStrobeMode,
                     cfg[0].readLaneStrobeMode});
                  curWait <= (hit[0] ? cfg[0].waitCount : 4'h0) | (hit[1] ? cfg[1].waitCount : 4'h0) |
                     (hit[2] ? cfg[2].waitCount : 4'h0);
                  beatsLeft <= nBeats;
                  curSize <= head.size;
                  curAddr <= head.addr;
                  // left-justify so the most significant piece goes first
                  shiftData <= (head.size == `XCSB_SZ_BYTE) ? {head.wdata[7:0], head.wdata[7:0], 16'h0000} :
                     (head.size == `XCSB_SZ_HALF) ? {head.wdata[15:0], 16'h0000} : head.wdata;
                  gather <= 32'h0000_0000;
                  extWriteN <= !head.write;
                  state <= ST_ADDR;
               end
            end
            ST_ADDR: begin
               waitCnt <= 4'h0;
               state <= ST_DATA;
            end
            ST_DATA: begin
               // waits stretch this phase until the cycle may end
               if (cycleEnd) begin
                  if (curWide && (curSize == `XCSB_SZ_BYTE)) begin
                     // a byte on a wide port sits on the lane its low address bit picks
                     gather <= {gather[23:0], curAddr[0] ? dinSync[7:0] : dinSync[15:8]};
                  end else begin
                     gather <= curWide ? {gather[15:0], dinSync} : {gather[23:0], dinSync[15:8]};
                  end
                  state <= ST_HOLD;
               end else if (waitCnt != 4'hF) begin
                  waitCnt <= waitCnt + 4'h1;
               end
            end
            ST_HOLD: begin
               shiftData <= curWide ? {shiftData[15:0], 16'h0000} : {shiftData[23:0], 8'h00};
               curAddr <= stepAddr;
               if (beatsLeft == 3'h1) begin
                  rspValid <= 1'b1;
                  rsp.err <= 1'b0;
                  rsp.rdata <= gather;
                  extWriteN <= 1'b1;
                  state <= ST_IDLE;
               end else begin
                  state <= ST_ADDR;
               end
               beatsLeft <= beatsLeft - 3'h1;
            end
            default: state <= ST_IDLE;
         endcase
      end
   end
   //==========================================================
   // rising-edge address and write data
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         extAddr <= '0;
         extDataOut <= 16'h0000;
         extDataOe <= 1'b0;
      end else begin
         // the address stands from the rising edge that opens the address phase
         if (state == ST_IDLE && headValid) begin
            extAddr <= head.addr[`XCSB_ADDR_W-1:0];
         end else if (state == ST_HOLD) begin
            extAddr <= stepAddr[`XCSB_ADDR_W-1:0];
         end else begin
            extAddr <= curAddr[`XCSB_ADDR_W-1:0];
         end
         extDataOut <= shiftData[31:16];  // all lanes driven
         extDataOe <= !extWriteN && (state != ST_IDLE);
      end
   end

   //==========================================================
   // falling-edge strobes; switched on every falling edge of the core clock
   function automatic logic [1:0] laneDecode(input logic wide, input logic [1:0] sz, input logic a0);
      if (!wide) begin
         return 2'b01;
      end else if (sz == `XCSB_SZ_BYTE) begin
         return a0 ? 2'b10 : 2'b01;
      end
      return 2'b00;
   endfunction
   logic active;
   assign active = (state == ST_ADDR) || (state == ST_DATA);
   always_ff @(negedge clk or negedge rstn) begin
      if (!rstn) begin
         chipSelN <= '1;
         readStrobeN <= 1'b1;
         lane_strobe_n <= 2'b11;
         addr_strobe_n <= 1'b1;
         addrStrobeOe <= 1'b0;
      end else begin
         chipSelN <= active ? ~curSel : '1;
         readStrobeN <= !(active && extWriteN && (curSel != '0));
         lane_strobe_n <= (active && (!extWriteN || curBem)) ? laneDecode(curWide, curSize, curAddr[0]) : 2'b11;
         addr_strobe_n <= !active;
         addrStrobeOe <= !shareAckMode;
      end
   end
   // bus clock out toggles on each rising core clock edge, at half the core rate
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         bus_clock_out <= 1'b0;
      end else begin
         bus_clock_out <= !bus_clock_out;
      end
   end
endmodule

// file: xcsb_fifo.sv
// request FIFO in front of the external bus engine
module xcsb_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // filling side
   input wire logic inValid,
   output logic inReady,
   input wire logic [WIDTH-1:0] inData,
   // draining side
   output logic outValid,
   input wire logic outReady,
   output logic [WIDTH-1:0] outData
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW-1:0] wrPtr;
   logic [AW-1:0] rdPtr;
   logic [AW:0] count;
   logic doWr;
   logic doRd;
   assign doWr = inValid && inReady;
   assign doRd = outValid && outReady;
   assign inReady = (count != (AW+1)'(DEPTH));  // full at DEPTH entries
   assign outValid = (count != '0);
   assign outData = mem[rdPtr];
   // storage write
   always_ff @(posedge clk) begin
      if (doWr) begin
         mem[wrPtr] <= inData;
      end
   end
   // pointers and fill level
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         wrPtr <= '0;
         rdPtr <= '0;
         count <= '0;
      end else begin
         if (doWr) begin
            wrPtr <= wrPtr + AW'(1);
         end
         if (doRd) begin
            rdPtr <= rdPtr + AW'(1);
         end
         count <= count + (AW+1)'(doWr) - (AW+1)'(doRd);
      end
   end
endmodule

// file: xcsb_map.svh
// constants for the external chip-select bus front end
//==========================================================
`ifndef XCSB_MAP_SVH
`define XCSB_MAP_SVH
`define XCSB_NUM_CS 3
`define XCSB_ADDR_W 22
`define XCSB_HI_LSB 16
`define XCSB_SZ_BYTE 2'h0
`define XCSB_SZ_HALF 2'h1
`define XCSB_SZ_WORD 2'h2
`define XCSB_SZ_LINE 2'h3
`define XCSB_FIFO_DEPTH 16
`define XCSB_BYTES_8 3'h4
`define XCSB_BYTES_16 3'h2
`endif

// file: xcsb_mem_model.sv
// byte memory with a slow or prompt acknowledge on the far side of the bus
module xcsb_mem_model (
   // clock
   input wire logic clk,
   // bus from the unit
   input wire logic [21:0] extAddr,
   input wire logic extWriteN,
   input wire logic [15:0] extDataOut,
   input wire logic [2:0] chipSelN,
   input wire logic readStrobeN,
   input wire logic [1:0] lane_strobe_n,
   // acknowledge behaviour
   input wire logic ackEn,
   input wire logic [7:0] ackDelay,
   // answers
   output logic [15:0] extDataIn,
   output logic transfer_ack_n
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [7:0] mem [32];
   logic [7:0] selCnt = 8'h00;
   logic [4:0] a;
   assign a = extAddr[4:0];
   initial begin
      for (int i = 0; i < 32; i++) mem[i] = 8'hA0 + 8'(i);
      transfer_ack_n = 1'b1;
      extDataIn = 16'h0000;
   end
   // upper lane is the lower byte address; last capture before release wins
   always @(posedge clk) begin
      if (!(&chipSelN) && !extWriteN && !lane_strobe_n[1]) mem[a] <= extDataOut[15:8];
      if (!(&chipSelN) && !extWriteN && !lane_strobe_n[0]) mem[a | 5'h01] <= extDataOut[7:0];
   end
   // released bus flips every cycle so stale data never looks valid
   always @(posedge clk) begin
      if (!(&chipSelN) && !readStrobeN) extDataIn <= {mem[a], mem[a | 5'h01]};
      else extDataIn <= ~extDataIn;
   end
   // one acknowledge pulse per beat, a set time after select
   always @(posedge clk) begin
      if (&chipSelN) selCnt <= 8'h00;
      else if (ackEn && selCnt != 8'hFF) selCnt <= selCnt + 8'h01;
      transfer_ack_n <= !(ackEn && !(&chipSelN) && selCnt == ackDelay);
   end
endmodule

// file: xcsb_pkg.sv
// types for the external chip-select bus front end
package xcsb_pkg;
   // one chip-select window configuration
   typedef struct packed {
      logic [15:0] base;
      logic [15:0] ignoreMask;
      logic writeProtect;
      logic valid;
      logic [3:0] waitCount;
      logic autoAck;
      logic [1:0] portWidth;
      logic readLaneStrobeMode;
   } xcsb_cfg_t;
   // one internal access request
   typedef struct packed {
      logic [31:0] addr;
      logic write;
      logic [1:0] size;
      logic [31:0] wdata;
   } xcsb_req_t;
   // one internal answer
   typedef struct packed {
      logic [31:0] rdata;
      logic err;
   } xcsb_rsp_t;
   typedef enum logic [3:0] {
      ST_IDLE = 4'b0001,
      ST_ADDR = 4'b0010,
      ST_DATA = 4'b0100,
      ST_HOLD = 4'b1000
   } xcsb_state_t;
endpackage

// file: xcsb_props.sv
// checker for the external chip-select bus front end
`include "xcsb_map.svh"
module xcsb_props
   import xcsb_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic rstn,
   // straps and window setup
   input wire logic boot_width_pin,
   input wire xcsb_cfg_t cfgIn [`XCSB_NUM_CS],
   input wire logic [`XCSB_NUM_CS-1:0] cfgWrite,
   // internal answer and status
   input wire logic rspValid,
   input wire xcsb_rsp_t rsp,
   input wire logic globalMode,
   // external bus
   input wire logic [`XCSB_ADDR_W-1:0] extAddr,
   input wire logic extWriteN,
   input wire logic [15:0] extDataOut,
   input wire logic [`XCSB_NUM_CS-1:0] chipSelN,
   input wire logic readStrobeN,
   input wire logic [1:0] lane_strobe_n,
   input wire logic shareAckMode,
   input wire logic addrStrobeOe
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clk); endclocking
   default disable iff (!rstn);
   logic [5:0] strobeAtRise;
   logic [38:0] busAtFall;
   // ==========================================================
   // edge helpers
   // strobes as they stood at the last rising edge
   always_ff @(posedge clk) begin
      strobeAtRise <= {chipSelN, readStrobeN, lane_strobe_n};
   end
   // address side as it stood at the last falling edge
   always_ff @(negedge clk) begin
      busAtFall <= {extAddr, extWriteN, extDataOut};
   end
   sequence cs0Valid_s;
      cfgWrite[0] && cfgIn[0].valid;
   endsequence
   sequence leaveGlobal_s;
      ##[1:3] !globalMode;
   endsequence
   // ==========================================================
   // assertions
   strobe_on_fall_a: assert property (@(negedge clk)
      {chipSelN, readStrobeN, lane_strobe_n} == strobeAtRise) else $error("strobe moved on rising edge");
   bus_on_rise_a: assert property (
      {extAddr, extWriteN, extDataOut} == busAtFall) else $error("address side moved on falling edge");
   read_needs_cs_a: assert property (
      !readStrobeN |-> chipSelN != 3'h7) else $error("read strobe without select");
   error_no_cs_a: assert property (
      rspValid && rsp.err |-> &chipSelN) else $error("error answer with select low");
   global_sticky_a: assert property (
      !globalMode |=> !globalMode) else $error("global mode came back");
   global_exit_a: assert property (
      globalMode ##0 cs0Valid_s |-> leaveGlobal_s) else $error("global mode not left");
   global_only_a: assert property (
      globalMode && $past(globalMode) |-> chipSelN[2:1] == 2'h3) else $error("upper select in global mode");
   global_cs0_a: assert property (
      globalMode && !readStrobeN |-> !chipSelN[0]) else $error("select zero missing");
   boot_lane8_a: assert property (
      globalMode && !boot_width_pin && lane_strobe_n != 2'h3 |-> lane_strobe_n == 2'h1)
      else $error("wrong lane on narrow port");
   shared_pin_a: assert property (
      shareAckMode && $past(shareAckMode) && $past(shareAckMode, 2) |-> !addrStrobeOe)
      else $error("strobe driven on ack pin");
endmodule
bind xcsb_external_bus_unit xcsb_props xcsb_props_i (
   .clk(clk), .rstn(rstn), .boot_width_pin(boot_width_pin), .cfgIn(cfgIn), .cfgWrite(cfgWrite),
   .rspValid(rspValid), .rsp(rsp), .globalMode(globalMode), .extAddr(extAddr), .extWriteN(extWriteN),
   .extDataOut(extDataOut), .chipSelN(chipSelN), .readStrobeN(readStrobeN),
   .lane_strobe_n(lane_strobe_n), .shareAckMode(shareAckMode), .addrStrobeOe(addrStrobeOe)
);
